// *** logic/acc_cfg.svh ***
// constants for the converter control block
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
`define ACC_OFS_CHSEL 8'h00
`define ACC_OFS_CTRLA 8'h04
`define ACC_OFS_RESL 8'h08
`define ACC_OFS_RESH 8'h0C
`define ACC_OFS_CTRLB 8'h10
`define ACC_B_EN 7
`define ACC_B_START 6
`define ACC_B_AUTO 5
`define ACC_B_FLAG 4
`define ACC_B_IE 3
`define ACC_B_LADJ 5
`define ACC_CONV_NORMAL 5'h0D
`define ACC_CONV_FIRST 5'h19
`define ACC_SRC_SELF 3'h0
`define ACC_CH_SE_MAX 5'h07
`define ACC_CH_GAIN_LO 5'h08
`define ACC_CH_GAIN_HI 5'h0F
`define ACC_CH_DIFF_LO 5'h10
`define ACC_CH_DIFF_HI 5'h17
`define ACC_CH_UNITY_LO 5'h18
`define ACC_CH_UNITY_HI 5'h19
`define ACC_CH_BANDGAP 5'h1E
`define ACC_CH_GROUND 5'h1F
`define ACC_NEG_COMMON 3'h1
`define ACC_GAIN_1X 2'h0
`define ACC_GAIN_10X 2'h1
`define ACC_GAIN_200X 2'h2
`endif

// *** logic/acc_pkg.sv ***
// types for the converter control block
`default_nettype none
package acc_pkg;
  typedef enum logic [1:0] {ACC_IDLE, ACC_PEND, ACC_CONV} acc_state_e;
endpackage
`default_nettype wire

// *** logic/acc_top.sv ***
// converter control: AHB-Lite registers, prescaler, sequencing, result bytes
//
// Behaviour
// - 10-bit code from core, zero to reference
// - reference select drives reference pin source
// - channel field picks input; single-ended bypasses gain
// - gain 1x, 10x, 200x on two pairs
// - seven differential codes, common negative input
// - selections apply only when enabled; off unpowered
// - right aligned default, left when selected
// - low read locks bytes until high read
// - done flag set even if result lost
// - start bit begins conversion, clears at end
// - channel change applies after current conversion
// - auto trigger enable uses selected source
// - trigger rising edge resets prescaler, starts
// - edges during conversion ignored, no level restart
// - trigger flags set regardless; software clears them
// - own flag as source: free running
// - start works in auto mode; reads busy
// - 13 cycles normal, 25 first conversion
// - completion writes data, sets flag, clears start
// - prescaler runs while enabled, reset otherwise
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"
module acc_top
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [7:1] trig_i,
  input wire logic irq_ack_i,
  input wire logic [9:0] core_result_i,
  output logic irq_o,
  output logic power_o,
  output logic [1:0] ref_sel_o,
  output logic [2:0] pos_sel_o,
  output logic [2:0] neg_sel_o,
  output logic diff_o,
  output logic [1:0] gain_o,
  output logic bypass_o,
  output logic core_start_o,
  output logic core_tick_o
);
  // software-visible registers
  logic [7:0] chsel_reg;
  logic en_reg, auto_reg, flag_reg, ie_reg;
  logic [2:0] ps_reg;
  logic [2:0] src_reg;
  logic [9:0] data_reg;
  logic lock_reg;
  // sequencing
  acc_state_e state_reg, state_next;
  logic [6:0] ps_cnt_reg;
  logic [4:0] cnt_reg;
  logic first_reg;
  logic trig_prev_reg;
  logic [7:0] lat_reg;
  // bus
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic irq_reg, power_reg, start_reg, tick_reg, bypass_reg, diff_reg;
  logic [1:0] ref_reg, gain_reg;
  logic [2:0] pos_reg, neg_reg;

  wire addr_ok = hsel_i & htrans_i[1] & hready_i;
  wire wr_a = wr_pend_reg & (addr_reg == `ACC_OFS_CTRLA);
  wire wr_m = wr_pend_reg & (addr_reg == `ACC_OFS_CHSEL);
  wire wr_b = wr_pend_reg & (addr_reg == `ACC_OFS_CTRLB);
  wire rd_l = rd_pend_reg & (addr_reg == `ACC_OFS_RESL);
  wire rd_h = rd_pend_reg & (addr_reg == `ACC_OFS_RESH);
  wire wr_start = wr_a & hwdata_i[`ACC_B_START];
  wire wr_clr = wr_a & hwdata_i[`ACC_B_FLAG];
  wire ladj = chsel_reg[`ACC_B_LADJ];

  // prescaler: divide by 2^(ps+1), ps 7 same as ps 6; tick on all selected bits set
  wire [6:0] ps_mask = 7'h7F >> (3'h6 - ((ps_reg == 3'h7) ? 3'h6 : ps_reg));
  wire tick = en_reg & ((ps_cnt_reg & ps_mask) == ps_mask);

  // trigger selection and edge detection
  wire trig_sel = (src_reg == `ACC_SRC_SELF) ? flag_reg : trig_i[src_reg];
  wire trig_rise = en_reg & auto_reg & trig_sel & ~trig_prev_reg & (src_reg != `ACC_SRC_SELF);
  wire free_run = auto_reg & (src_reg == `ACC_SRC_SELF);
  wire busy = (state_reg == ACC_CONV);
  wire [4:0] conv_last = (first_reg ? `ACC_CONV_FIRST : `ACC_CONV_NORMAL) - 5'h01;
  wire done_w = busy & tick & (cnt_reg == conv_last);
  wire trig_go = trig_rise & ~busy;
  wire start_view = (state_reg != ACC_IDLE);
  wire set_flag = done_w;

  // read data view; alignment applied to stored 10-bit code
  wire [7:0] res_lo = ladj ? {data_reg[1:0], 6'h00} : data_reg[7:0];
  wire [7:0] res_hi = ladj ? data_reg[9:2] : {6'h00, data_reg[9:8]};
  wire [7:0] ctrla_view = {en_reg, start_view, auto_reg, flag_reg, ie_reg, ps_reg};
  wire [7:0] rd_mux =
    (addr_reg == `ACC_OFS_CHSEL) ? chsel_reg :
    (addr_reg == `ACC_OFS_CTRLA) ? ctrla_view :
    (addr_reg == `ACC_OFS_RESL) ? res_lo :
    (addr_reg == `ACC_OFS_RESH) ? res_hi :
    (addr_reg == `ACC_OFS_CTRLB) ? {5'h00, src_reg} : 8'h00;

  // channel decode from latched selection
  wire [4:0] ch = lat_reg[4:0];
  wire is_se = (ch <= `ACC_CH_SE_MAX) | (ch == `ACC_CH_BANDGAP) | (ch == `ACC_CH_GROUND);
  wire is_gain = (ch >= `ACC_CH_GAIN_LO) & (ch <= `ACC_CH_GAIN_HI);
  wire is_unity = (ch >= `ACC_CH_UNITY_LO) & (ch <= `ACC_CH_UNITY_HI);
  wire is_diff = (ch >= `ACC_CH_DIFF_LO) & (ch <= `ACC_CH_DIFF_HI) & (ch[2:0] != `ACC_NEG_COMMON);
  wire pair_hi = is_gain ? ch[0] : ch[0];
  wire [2:0] pair_pos = pair_hi ? 3'h3 : 3'h1;
  wire [2:0] pair_neg = pair_hi ? 3'h2 : 3'h0;
  wire [2:0] dec_pos = (is_gain | is_unity) ? pair_pos : ch[2:0];
  wire [2:0] dec_neg = (is_gain | is_unity) ? pair_neg : `ACC_NEG_COMMON;
  wire [1:0] dec_gain = is_gain ? (ch[2] ? `ACC_GAIN_200X : `ACC_GAIN_10X) : `ACC_GAIN_1X;
  wire dec_diff = is_gain | is_unity | is_diff;

  // conversion sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACC_IDLE: begin
        if (trig_go) begin
          state_next = ACC_CONV;
        end else if (wr_start) begin
          state_next = ACC_PEND;
        end
      end
      ACC_PEND: begin
        if (trig_go) begin
          state_next = ACC_CONV;
        end else if (tick) begin
          state_next = ACC_CONV;
        end
      end
      ACC_CONV: begin
        // level still high at the end does not restart; only a fresh edge does
        if (done_w) begin
          state_next = free_run ? ACC_CONV : ACC_IDLE;
        end
      end
      default: state_next = ACC_IDLE;
    endcase
    if (!en_reg) begin
      state_next = ACC_IDLE;
    end
  end

  wire conv_begin = (state_next == ACC_CONV) & (~busy | done_w);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ACC_IDLE;
      cnt_reg <= 5'h00;
      ps_cnt_reg <= 7'h00;
      trig_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_prev_reg <= trig_sel;
      // trigger restarts prescaler so delay to sampling is fixed
      if (!en_reg || trig_go) begin
        ps_cnt_reg <= 7'h00;
      end else begin
        ps_cnt_reg <= ps_cnt_reg + 7'h01;
      end
      if (conv_begin) begin
        cnt_reg <= 5'h00;
      end else if (busy && tick) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // first conversion after enabling is the long one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg <= 1'b1;
    end else if (!en_reg) begin
      first_reg <= 1'b1;
    end else if (done_w) begin
      first_reg <= 1'b0;
    end
  end

  // selection latch: tracks while idle, frozen during conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_reg <= 8'h00;
    end else if (!busy || done_w) begin
      lat_reg <= chsel_reg;
    end
  end

  // result bytes and lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_reg <= 10'h000;
      lock_reg <= 1'b0;
    end else begin
      if (done_w && !lock_reg) begin
        data_reg <= core_result_i;
      end
      if (rd_l) begin
        lock_reg <= 1'b1;
      end else if (rd_h) begin
        lock_reg <= 1'b0;
      end
    end
  end

  // control registers; completion set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chsel_reg <= 8'h00;
      en_reg <= 1'b0;
      auto_reg <= 1'b0;
      ie_reg <= 1'b0;
      ps_reg <= 3'h0;
      src_reg <= 3'h0;
      flag_reg <= 1'b0;
    end else begin
      if (wr_m) begin
        chsel_reg <= hwdata_i[7:0];
      end
      if (wr_a) begin
        en_reg <= hwdata_i[`ACC_B_EN];
        auto_reg <= hwdata_i[`ACC_B_AUTO];
        ie_reg <= hwdata_i[`ACC_B_IE];
        ps_reg <= hwdata_i[2:0];
      end
      if (wr_b) begin
        src_reg <= hwdata_i[2:0];
      end
      if (set_flag) begin
        flag_reg <= 1'b1;
      end else if (wr_clr || irq_ack_i) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // analog-facing outputs, all registered; nothing applied while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_reg <= 1'b0;
      ref_reg <= 2'h0;
      pos_reg <= 3'h0;
      neg_reg <= 3'h0;
      gain_reg <= 2'h0;
      diff_reg <= 1'b0;
      bypass_reg <= 1'b1;
      start_reg <= 1'b0;
      tick_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      power_reg <= en_reg;
      ref_reg <= en_reg ? lat_reg[7:6] : 2'h0;
      pos_reg <= en_reg ? dec_pos : 3'h0;
      neg_reg <= en_reg ? dec_neg : 3'h0;
      gain_reg <= en_reg ? dec_gain : `ACC_GAIN_1X;
      diff_reg <= en_reg & dec_diff;
      bypass_reg <= ~en_reg | is_se | ~dec_diff;
      start_reg <= conv_begin;
      tick_reg <= tick;
      irq_reg <= (flag_reg | set_flag) & ie_reg & ~(wr_clr | irq_ack_i) | set_flag & ie_reg;
    end
  end

  // AHB-Lite slave: writes zero-wait, reads one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_i;
      rd_pend_reg <= addr_ok & ~hwrite_i;
      if (addr_ok) begin
        addr_reg <= {haddr_i[7:2], 2'h0};
      end
      hready_reg <= ~(addr_ok & ~hwrite_i);
      if (rd_pend_reg) begin
        hrdata_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hready_reg;
  assign hresp_o = 1'b0;
  assign irq_o = irq_reg;
  assign power_o = power_reg;
  assign ref_sel_o = ref_reg;
  assign pos_sel_o = pos_reg;
  assign neg_sel_o = neg_reg;
  assign gain_o = gain_reg;
  assign diff_o = diff_reg;
  assign bypass_o = bypass_reg;
  assign core_start_o = start_reg;
  assign core_tick_o = tick_reg;

  // helper: ticks seen since the conversion began
  logic [5:0] chk_ticks_reg;
  logic chk_first_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_ticks_reg <= 6'h00;
      chk_first_reg <= 1'b0;
    end else if (conv_begin) begin
      chk_ticks_reg <= 6'h00;
      chk_first_reg <= first_reg & ~done_w;
    end else if (busy && tick) begin
      chk_ticks_reg <= chk_ticks_reg + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_conv_length: assert property (done_w |-> chk_ticks_reg == (chk_first_reg ? 6'h18 : 6'h0C))
    else $error("conversion length wrong");
  chk_flag_sets: assert property (done_w |=> flag_reg)
    else $error("done flag not set on completion");
  chk_lock_hold: assert property (done_w && lock_reg |=> $stable(data_reg))
    else $error("locked result bytes changed");
  chk_data_write: assert property (done_w && !lock_reg |=> data_reg == $past(core_result_i))
    else $error("result not captured");
  chk_start_clears: assert property (done_w && !free_run && en_reg |=> !start_view ##1 1)
    else $error("start bit not cleared at end");
  chk_off_quiet: assert property (!en_reg |=> !busy && !power_o && ref_sel_o == 2'h0)
    else $error("converter active while disabled");
  chk_ps_reset: assert property (!en_reg |=> ps_cnt_reg == 7'h00)
    else $error("prescaler running while disabled");
  chk_chan_frozen: assert property (busy && $past(busy) && !$past(done_w) |-> $stable(lat_reg))
    else $error("selection changed mid conversion");
  chk_edge_ignore: assert property (busy && !done_w && trig_rise && en_reg |=>
    busy && cnt_reg == $past(cnt_reg) + {4'h0, $past(tick)})
    else $error("edge restarted running conversion");
  chk_free_run: assert property (done_w && free_run && en_reg |=> busy && core_start_o)
    else $error("free running stopped");
  chk_flag_clear: assert property (flag_reg && wr_clr && !set_flag |=> !flag_reg)
    else $error("done flag not cleared by one");
endmodule // acc_top
`default_nettype wire

// *** sim/acc_core_model.sv ***
// stand-in for the converter core: code mirrors the selection at each start
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic start_i,
  input wire logic [2:0] pos_i,
  input wire logic [2:0] neg_i,
  input wire logic [1:0] gain_i,
  input wire logic diff_i,
  input wire logic bypass_i,
  output logic [9:0] code_o
);
  initial code_o = 10'h155;
  always @(posedge clk_i) begin
    if (!power_i) begin
      code_o <= ~code_o; // unpowered core gives no stable code
    end else if (start_i) begin
      code_o <= {pos_i, neg_i, gain_i, diff_i, bypass_i};
    end
  end
endmodule // acc_core_model
`default_nettype wire

// *** sim/acc_top_tb_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ack = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:1] trig = 7'h00;
  logic [31:0] seed = 32'h14E3F;
  logic [31:0] rd, hrdata;
  logic hrdy, hresp, irq, pwr, dif, byp, cst, ctk;
  logic [1:0] rsel, gain;
  logic [2:0] pos, neg;
  logic [9:0] code, m;
  int n_mismatch = 0, check_count = 0, ticks = 0, starts = 0, nt = 0, first, s0, i;

  acc_top dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .trig_i(trig), .irq_ack_i(ack), .core_result_i(code),
    .irq_o(irq), .power_o(pwr), .ref_sel_o(rsel), .pos_sel_o(pos), .neg_sel_o(neg), .diff_o(dif),
    .gain_o(gain), .bypass_o(byp), .core_start_o(cst), .core_tick_o(ctk));
  acc_core_model core (.clk_i(clk_i), .power_i(pwr), .start_i(cst), .pos_i(pos), .neg_i(neg),
    .gain_i(gain), .diff_i(dif), .bypass_i(byp), .code_o(code));

  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ticks counted from each conversion start; offset cancels in differences
  always @(posedge clk_i) begin
    ticks <= cst ? 0 : ticks + 32'(ctk);
    starts <= starts + 32'(cst);
    nt <= nt + 32'(ctk);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // packed as {pos, neg, gain, diff, bypass}
  function automatic logic [9:0] route(input logic [4:0] c);
    if (c <= 5'h07) return {c[2:0], 3'h0, 2'h0, 2'h1};
    if (c <= 5'h0F) return {c[0] ? 3'h3 : 3'h1, c[0] ? 3'h2 : 3'h0, c[2] ? 2'h2 : 2'h1, 2'h2};
    if (c <= 5'h17) return {c[2:0], 3'h1, 2'h0, 2'h2};
    return {c[0] ? 3'h3 : 3'h1, c[0] ? 3'h2 : 3'h0, 2'h0, 2'h2};
  endfunction
  function automatic logic [31:0] lo_b(input logic [9:0] v, input logic l);
    return l ? {24'h0, v[1:0], 6'h00} : {24'h0, v[7:0]};
  endfunction
  function automatic logic [31:0] hi_b(input logic [9:0] v, input logic l);
    return l ? {24'h0, v[9:2]} : {24'h0, 6'h00, v[9:8]};
  endfunction

  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wirq;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk_i);
  endtask
  task automatic rdres(input logic [9:0] v, input logic l);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, lo_b(v, l));
    xfer(1'b0, 8'h0C, 32'h0);
    chk(rd, hi_b(v, l));
  endtask

  initial begin
    cyc(6);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b1, 8'h00, 32'hD8);
    cyc(2);
    chk(32'({pwr, rsel}), 32'h0);
    xfer(1'b1, 8'h04, 32'h88);
    cyc(2);
    chk(32'({pwr, rsel}), 32'h7);
    for (i = 0; i < 26; i++) begin
      if (i != 17) begin
        xfer(1'b1, 8'h00, 32'(i));
        cyc(3);
        m = (i <= 7) ? 10'h383 : 10'h3FF;
        chk(32'({pos, neg, gain, dif, byp} & m), 32'(route(5'(i)) & m));
      end
    end
    seed = xs(seed);
    xfer(1'b1, 8'h14, seed);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    xfer(1'b1, 8'h00, 32'h18);
    xfer(1'b1, 8'h04, 32'hC8);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h40, 32'h40);
    xfer(1'b1, 8'h00, 32'h19);
    wirq;
    first = ticks;
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h98);
    rdres(route(5'h18), 1'b0);
    xfer(1'b1, 8'h04, 32'h88);
    cyc(2);
    chk(32'(irq), 32'h1);
    xfer(1'b1, 8'h04, 32'h98);
    cyc(2);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 8'h00, 32'h39);
    xfer(1'b1, 8'h04, 32'hC8);
    wirq;
    chk(32'(first - ticks), 32'h0C);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, lo_b(route(5'h19), 1'b1));
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    cyc(2);
    chk(32'(irq), 32'h0);
    xfer(1'b1, 8'h00, 32'h38);
    xfer(1'b1, 8'h04, 32'hC8);
    wirq;
    chk(32'(irq), 32'h1);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(rd, hi_b(route(5'h19), 1'b1));
    rdres(route(5'h19), 1'b1);
    xfer(1'b1, 8'h10, 32'h3);
    xfer(1'b1, 8'h04, 32'hB8);
    cyc(2);
    s0 = starts;
    trig <= 7'h04;
    cyc(4);
    chk(32'(starts - s0), 32'h1);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h40, 32'h40);
    for (i = 0; i < 10; i++) begin
      seed = xs(seed);
      trig <= seed[6:0];
      @(posedge clk_i);
    end
    trig <= 7'h04;
    wirq;
    cyc(60);
    chk(32'(starts - s0), 32'h1);
    trig <= 7'h00;
    cyc(2);
    trig <= 7'h04;
    cyc(4);
    chk(32'(starts - s0), 32'h2);
    // let the triggered conversion finish before the software start
    cyc(30);
    xfer(1'b1, 8'h04, 32'hF8);
    cyc(3);
    wirq;
    chk(32'(starts - s0), 32'h3);
    xfer(1'b1, 8'h10, 32'h0);
    xfer(1'b1, 8'h04, 32'hE0);
    s0 = starts;
    cyc(200);
    xfer(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h40, 32'h40);
    chk(32'(starts - s0 >= 5 && starts - s0 <= 8), 32'h1);
    xfer(1'b1, 8'h04, 32'hA2);
    cyc(2);
    s0 = nt;
    cyc(64);
    chk(32'(nt - s0), 32'h8);
    xfer(1'b1, 8'h04, 32'h0);
    cyc(2);
    s0 = nt;
    cyc(20);
    chk(32'({pwr, rsel}), 32'h0);
    chk(32'(nt - s0), 32'h0);
    report_and_stop;
  end

  initial begin
    cyc(20000);
    n_mismatch++;
    report_and_stop;
  end
endmodule // acc_top_tb_top
`default_nettype wire
